// File: hw/unmp_uart.sv
// Purpose: Serial port with 8/9-bit framing and multiprocessor receive filter
// Assumes: Classic Wishbone slave, control at 0x98 and buffer at 0x99, ack one cycle late
// Notes:   Baud fixed by UNMP_BIT_CYC
`timescale 1ns/1ps
`include "unmp_cfg.svh"
module unmp_uart
   import unmp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic       wb_sel_i,
   input  wire logic [7:0] wb_adr_i,
   input  wire logic [7:0] wb_dat_i,
   output logic      [7:0] wb_dat_o,
   output logic            wb_ack_o,
   input  wire logic       irq_en_i,
   output logic            irq_o,
   unmp_link_if.device     link
);
   localparam int BIT_CYC = `UNMP_BIT_CYC;
   localparam int HALF    = BIT_CYC / 2;

   logic [7:0]  ctrl;
   logic [7:0]  rx_buf;
   unmp_state_t tx_st;
   unmp_state_t rx_st;
   logic [15:0] tx_cnt;
   logic [15:0] rx_cnt;
   logic [3:0]  tx_bit;
   logic [3:0]  rx_bit;
   logic [8:0]  tx_sh;
   logic [8:0]  rx_sh;
   logic        tx_line;
   logic        rx_q;
   logic        tx_set;
   logic        rx_set;
   logic        rx_stop;

   wire nine       = ctrl[`UNMP_B_MODE];
   wire bus_req    = wb_cyc_i && wb_stb_i;
   wire wr_en      = bus_req && wb_ack_o && wb_we_i && wb_sel_i;
   wire wr_ctrl    = wr_en && (wb_adr_i == `UNMP_OFF_CTRL);
   wire wr_buf     = wr_en && (wb_adr_i == `UNMP_OFF_BUF);
   wire [7:0] rd_mux = (wb_adr_i == `UNMP_OFF_BUF) ? rx_buf
                       : (ctrl | (8'h01 << `UNMP_B_UNUSED));
   wire [3:0] nbits = nine ? 4'd9 : 4'd8;
   wire tx_tick    = (tx_cnt == 16'(BIT_CYC - 1));
   wire rx_tick    = (rx_cnt == 16'(BIT_CYC - 1));
   wire rx_mid     = (rx_cnt == 16'(HALF - 1));
   wire rx_in      = link.node_tx;
   wire rx_fall    = rx_q && !rx_in;
   wire rx_ninth   = nine ? rx_sh[8] : rx_in;
   wire pass       = !ctrl[`UNMP_B_MCE] || rx_ninth;
   wire accept     = rx_stop && !ctrl[`UNMP_B_RI] && pass;

   assign link.dev_tx = tx_line;
   assign irq_o       = irq_en_i && (ctrl[`UNMP_B_TI] || ctrl[`UNMP_B_RI]);

   // Bus port: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 8'h00;
      end
      else
      begin
         wb_ack_o <= bus_req && !wb_ack_o;
         if (bus_req && !wb_ack_o)
            wb_dat_o <= rd_mux;
      end
   end

   // Control register: hardware set wins over software clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl <= `UNMP_CTRL_RST;
      else
      begin
         if (wr_ctrl)
            ctrl <= {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
         if (tx_set)
            ctrl[`UNMP_B_TI] <= 1'b1;
         if (accept)
         begin
            ctrl[`UNMP_B_RI]  <= 1'b1;
            ctrl[`UNMP_B_RB8] <= rx_ninth;
         end
      end
   end

   // Transmitter
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_st   <= UNMP_IDLE;
         tx_cnt  <= 16'h0000;
         tx_bit  <= 4'h0;
         tx_sh   <= 9'h000;
         tx_line <= 1'b1;
         tx_set  <= 1'b0;
      end
      else
      begin
         tx_set <= 1'b0;
         tx_cnt <= tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
         unique case (tx_st)
            UNMP_IDLE:
            begin
               tx_cnt <= 16'h0000;
               if (wr_buf)
               begin
                  tx_sh   <= {ctrl[`UNMP_B_TB8], wb_dat_i};
                  tx_line <= 1'b0;
                  tx_st   <= UNMP_START;
               end
            end
            UNMP_START:
               if (tx_tick)
               begin
                  tx_line <= tx_sh[0];
                  tx_sh   <= {1'b1, tx_sh[8:1]};
                  tx_bit  <= 4'h1;
                  tx_st   <= UNMP_DATA;
               end
            UNMP_DATA:
               if (tx_tick)
               begin
                  if (tx_bit == nbits)
                  begin
                     tx_line <= 1'b1;
                     tx_set  <= 1'b1;
                     tx_st   <= UNMP_TAIL;
                  end
                  else
                  begin
                     tx_line <= tx_sh[0];
                     tx_sh   <= {1'b1, tx_sh[8:1]};
                     tx_bit  <= tx_bit + 4'h1;
                  end
               end
            UNMP_TAIL:
               if (tx_tick)
                  tx_st <= UNMP_IDLE;
         endcase
      end
   end

   // Receiver: samples mid-bit
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_st   <= UNMP_IDLE;
         rx_cnt  <= 16'h0000;
         rx_bit  <= 4'h0;
         rx_sh   <= 9'h000;
         rx_q    <= 1'b1;
         rx_stop <= 1'b0;
         rx_buf  <= 8'h00;
      end
      else
      begin
         rx_q    <= rx_in;
         rx_stop <= 1'b0;
         rx_cnt  <= rx_tick ? 16'h0000 : rx_cnt + 16'h0001;
         if (accept)
            rx_buf <= nine ? rx_sh[7:0] : rx_sh[8:1];
         unique case (rx_st)
            UNMP_IDLE:
            begin
               rx_cnt <= 16'h0000;
               if (rx_fall && ctrl[`UNMP_B_REN])
                  rx_st <= UNMP_START;
            end
            UNMP_START:
               if (rx_mid)
               begin
                  rx_cnt <= 16'h0000;
                  rx_bit <= 4'h0;
                  rx_st  <= rx_in ? UNMP_IDLE : UNMP_DATA;
               end
            UNMP_DATA:
               if (rx_tick)
               begin
                  rx_sh  <= {rx_in, rx_sh[8:1]};
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_bit == nbits - 4'h1)
                     rx_st <= UNMP_TAIL;
               end
            UNMP_TAIL:
               if (rx_tick)
               begin
                  rx_stop <= 1'b1;
                  rx_st   <= UNMP_IDLE;
               end
         endcase
      end
   end
endmodule : unmp_uart

// File: hw/unmp_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial port
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef UNMP_CFG_SVH
`define UNMP_CFG_SVH
`define UNMP_CLK_HZ          10000000
`define UNMP_BAUD            115200
`define UNMP_BIT_CYC         (`UNMP_CLK_HZ / `UNMP_BAUD)
`define UNMP_OFF_CTRL        8'h98
`define UNMP_OFF_BUF         8'h99
`define UNMP_CTRL_RST        8'h00
`define UNMP_B_MODE          7
`define UNMP_B_UNUSED        6
`define UNMP_B_MCE           5
`define UNMP_B_REN           4
`define UNMP_B_TB8           3
`define UNMP_B_RB8           2
`define UNMP_B_TI            1
`define UNMP_B_RI            0
`define UNMP_WB_CTRL         4'h0
`define UNMP_WB_TXDATA       4'h4
`define UNMP_WB_RXDATA       4'h8
`define UNMP_WB_STATUS       4'hc
`define UNMP_WB_MASK         4'h0
`endif

// File: hw/unmp_pkg.sv
// Purpose: Types shared by both ends of the serial link
// Assumes: Nothing
// Notes:   Constants live in unmp_cfg.svh
package unmp_pkg;
   typedef enum logic [1:0] {UNMP_IDLE, UNMP_START, UNMP_DATA, UNMP_TAIL} unmp_state_t;
endpackage : unmp_pkg

// File: hw/unmp_link_if.sv
// Purpose: Serial line between the device and the remote node
// Assumes: Both ends on clk_i
// Notes:   Each end drives its own transmit line
`timescale 1ns/1ps
interface unmp_link_if;
   logic dev_tx;
   logic node_tx;
   modport device (output dev_tx, input node_tx);
   modport node   (output node_tx, input dev_tx);
endinterface : unmp_link_if

// File: hw/unmp_node.sv
// Purpose: Remote node: byte-wide serial transmitter and receiver, 8 or 9-bit
// Assumes: Same bit time as the device
// Notes:   Sends ninth bit as given by user; 1 marks addresses
`timescale 1ns/1ps
`include "unmp_cfg.svh"
module unmp_node
   import unmp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       nine_i,
   input  wire logic       send_i,
   input  wire logic [8:0] send_data_i,
   output logic            busy_o,
   output logic            recv_o,
   output logic      [8:0] recv_data_o,
   unmp_link_if.node       link
);
   localparam int BIT_CYC = `UNMP_BIT_CYC;
   localparam int HALF    = BIT_CYC / 2;

   unmp_state_t tx_st;
   unmp_state_t rx_st;
   logic [15:0] tx_cnt;
   logic [15:0] rx_cnt;
   logic [3:0]  tx_left;
   logic [3:0]  rx_bit;
   logic [9:0]  tx_sh;
   logic [9:0]  rx_sh;
   logic        rx_q;

   wire tx_tick = (tx_cnt == 16'(BIT_CYC - 1));
   wire rx_tick = (rx_cnt == 16'(BIT_CYC - 1));
   wire rx_mid  = (rx_cnt == 16'(HALF - 1));
   wire [3:0] nb = nine_i ? 4'd10 : 4'd9;

   assign link.node_tx = tx_sh[0];
   assign busy_o       = (tx_st != UNMP_IDLE);

   // Sender: start, data LSB first, optional ninth, stop
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_st   <= UNMP_IDLE;
         tx_cnt  <= 16'h0000;
         tx_left <= 4'h0;
         tx_sh   <= 10'h3ff;
      end
      else
      begin
         tx_cnt <= tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
         if (tx_st == UNMP_IDLE)
         begin
            tx_cnt <= 16'h0000;
            if (send_i)
            begin
               tx_sh   <= nine_i ? {send_data_i, 1'b0}
                                 : {1'b1, send_data_i[7:0], 1'b0};
               tx_left <= nb;
               tx_st   <= UNMP_DATA;
            end
         end
         else if (tx_tick)
         begin
            tx_sh   <= {1'b1, tx_sh[9:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h0)
               tx_st <= UNMP_IDLE;
         end
      end
   end

   // Receiver: reports data plus ninth or stop bit
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_st       <= UNMP_IDLE;
         rx_cnt      <= 16'h0000;
         rx_bit      <= 4'h0;
         rx_sh       <= 10'h000;
         rx_q        <= 1'b1;
         recv_o      <= 1'b0;
         recv_data_o <= 9'h000;
      end
      else
      begin
         rx_q   <= link.dev_tx;
         recv_o <= 1'b0;
         rx_cnt <= rx_tick ? 16'h0000 : rx_cnt + 16'h0001;
         unique case (rx_st)
            UNMP_IDLE:
            begin
               rx_cnt <= 16'h0000;
               if (rx_q && !link.dev_tx)
                  rx_st <= UNMP_START;
            end
            UNMP_START:
               if (rx_mid)
               begin
                  rx_cnt <= 16'h0000;
                  rx_bit <= 4'h0;
                  rx_st  <= link.dev_tx ? UNMP_IDLE : UNMP_DATA;
               end
            UNMP_DATA:
               if (rx_tick)
               begin
                  rx_sh  <= {link.dev_tx, rx_sh[9:1]};
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_bit == nb - 4'h1)
                     rx_st <= UNMP_TAIL;
               end
            UNMP_TAIL:
            begin
               recv_o      <= 1'b1;
               recv_data_o <= nine_i ? rx_sh[8:0] : rx_sh[9:1];
               rx_st       <= UNMP_IDLE;
            end
         endcase
      end
   end
endmodule : unmp_node

// File: verif/unmp_link_monitor.sv
// Purpose: Wire checks on the serial link between the two ends
// Assumes: Both ends run on clk_i, exact bit time
// Notes:   Low runs counted to check bit lengths and stop level
`timescale 1ns/1ps
`include "unmp_cfg.svh"
module unmp_link_monitor (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic dev_tx,
   input  wire logic node_tx
);
   localparam int BIT    = `UNMP_BIT_CYC;
   localparam int MAXLOW = 10 * BIT;
   logic [10:0] dev_low;
   logic [10:0] node_low;
   // Length of the current low run on each line
   always_ff @(posedge clk_i)
   begin
      dev_low  <= (rst_i || dev_tx) ? 11'h000 : dev_low + 11'h001;
      node_low <= (rst_i || node_tx) ? 11'h000 : node_low + 11'h001;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   dev_idle_reset_a: assert property ($fell(rst_i) |-> dev_tx [*2])
      else $error("device line not idle after reset");
   node_idle_reset_a: assert property ($fell(rst_i) |-> node_tx [*2])
      else $error("node line not idle after reset");
   dev_start_hold_a: assert property ($fell(dev_tx) |-> !dev_tx [*8])
      else $error("device start bit too short");
   node_start_hold_a: assert property ($fell(node_tx) |-> !node_tx [*8])
      else $error("node start bit too short");
   dev_bit_len_a: assert property ($rose(dev_tx) |-> (dev_low % BIT) == 0)
      else $error("device low run not whole bits");
   node_bit_len_a: assert property ($rose(node_tx) |-> (node_low % BIT) == 0)
      else $error("node low run not whole bits");
   dev_stop_high_a: assert property (dev_low <= MAXLOW)
      else $error("device stop bit missing");
   node_stop_high_a: assert property (node_low <= MAXLOW)
      else $error("node stop bit missing");
endmodule : unmp_link_monitor

// File: verif/unmp_uart_tb.sv
// Purpose: Self-checking bench for the serial port and remote node
// Assumes: Classic Wishbone master that waits for ack
// Notes:   Wire sampled mid-bit on the falling clock edge
`timescale 1ns/1ps
`include "unmp_cfg.svh"
module unmp_uart_tb;
   logic       clk_i       = 1'b0;
   logic       rst_i       = 1'b1;
   logic       wb_cyc_i    = 1'b0;
   logic       wb_stb_i    = 1'b0;
   logic       wb_we_i     = 1'b0;
   logic       wb_sel_i    = 1'b0;
   logic [7:0] wb_adr_i    = 8'h00;
   logic [7:0] wb_dat_i    = 8'h00;
   logic [7:0] wb_dat_o;
   logic       wb_ack_o;
   logic       irq_en_i    = 1'b1;
   logic       irq_o;
   logic       nine_i      = 1'b0;
   logic       send_i      = 1'b0;
   logic [8:0] send_data_i = 9'h000;
   logic       busy_o;
   logic       recv_o;
   logic [8:0] recv_data_o;
   logic [8:0] got         = 9'h000;
   int         fails       = 0;
   int         cmp_count   = 0;
   unmp_link_if link ();
   unmp_uart u_unmp_uart (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_en_i(irq_en_i),
      .irq_o(irq_o), .link(link));
   unmp_node u_unmp_node (.clk_i(clk_i), .rst_i(rst_i), .nine_i(nine_i), .send_i(send_i),
      .send_data_i(send_data_i), .busy_o(busy_o), .recv_o(recv_o),
      .recv_data_o(recv_data_o), .link(link));
   unmp_link_monitor u_unmp_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
      .dev_tx(link.dev_tx), .node_tx(link.node_tx));
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (recv_o) got <= recv_data_o;
   task automatic summarize;
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] seen);
      cmp_count++;
      if (exp !== seen)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One classic cycle: request held until ack is seen at a rising edge
   task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] v);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 1'b1;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      n = 1;
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      v = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      wb_sel_i <= 1'b0;
      if (wb_ack_o !== 1'b1)
      begin
         fails++;
         summarize();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      bus(1'b1, a, d, v);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      bus(1'b0, a, 8'h00, v);
   endtask : rd
   // Device sends one frame, wire and node result judged
   task automatic tx(input logic [7:0] ctl, input logic [7:0] d);
      logic [9:0] bits;
      logic [7:0] c;
      int         n;
      bits = {ctl[7] ? ctl[3] : 1'b1, d, 1'b0};
      nine_i <= ctl[7];
      wr(`UNMP_OFF_CTRL, ctl);
      wr(`UNMP_OFF_BUF, d);
      n = 0;
      while (link.dev_tx !== 1'b0 && n < 300)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n == 300)
      begin
         fails++;
         summarize();
      end
      repeat (43) @(negedge clk_i);
      for (int i = 0; i < (ctl[7] ? 10 : 9); i++)
      begin
         chk("tx bit", 9'(bits[i]), 9'(link.dev_tx));
         chk("tx done early", 9'h000, 9'(irq_o));
         repeat (86) @(negedge clk_i);
      end
      chk("tx stop", 9'h001, 9'(link.dev_tx));
      chk("tx irq", 9'(irq_en_i), 9'(irq_o));
      rd(`UNMP_OFF_CTRL, c);
      chk("tx done", 9'h001, 9'(c[1]));
      repeat (100) @(negedge clk_i);
      chk("node data", {bits[9], d}, got);
      rd(`UNMP_OFF_CTRL, c);
      chk("tx done held", 9'h001, 9'(c[1]));
      wr(`UNMP_OFF_CTRL, ctl);
      rd(`UNMP_OFF_CTRL, c);
      chk("tx done cleared", 9'h000, 9'(c[1]));
   endtask : tx
   // Node sends one frame, device flags and buffer judged
   task automatic rx(input logic [7:0] ctl, input logic [8:0] d, input logic ri,
                     input logic [8:0] exp);
      logic [7:0] c;
      logic [7:0] b;
      int         n;
      nine_i <= ctl[7];
      wr(`UNMP_OFF_CTRL, ctl);
      @(posedge clk_i);
      send_data_i <= d;
      send_i      <= 1'b1;
      @(posedge clk_i);
      send_i      <= 1'b0;
      n = 0;
      @(negedge clk_i);
      while (busy_o !== 1'b0 && n < 1500)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n == 1500)
      begin
         fails++;
         summarize();
      end
      repeat (200) @(negedge clk_i);
      rd(`UNMP_OFF_CTRL, c);
      rd(`UNMP_OFF_BUF, b);
      chk("rx done", 9'(ri), 9'(c[0]));
      chk("rx data", exp, {c[2], b});
      chk("rx irq", 9'(ri & irq_en_i), 9'(irq_o));
   endtask : rx
   initial
   begin : main
      logic [7:0] v;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`UNMP_OFF_CTRL, v);
      chk("ctrl reset", 9'h040, 9'(v));
      wr(8'h9a, 8'hff);
      rd(`UNMP_OFF_CTRL, v);
      chk("ctrl unmapped", 9'h040, 9'(v));
      tx(8'h88, 8'ha5);
      tx(8'h80, 8'h3c);
      tx(8'h08, 8'h81);
      rx(8'hb0, 9'h033, 1'b0, 9'h000);
      rx(8'hb0, 9'h1c4, 1'b1, 9'h1c4);
      rx(8'hb5, 9'h1e7, 1'b1, 9'h1c4);
      rx(8'h90, 9'h055, 1'b1, 9'h055);
      rx(8'h80, 9'h1aa, 1'b0, 9'h055);
      rx(8'h30, 9'h077, 1'b1, 9'h177);
      irq_en_i <= 1'b0;
      @(negedge clk_i);
      chk("irq masked", 9'h000, 9'(irq_o));
      summarize();
   end
endmodule : unmp_uart_tb
